// ==== design/adcbr_consts.vh ====
// Constants for the converter busy, shared pin and range select block.
`ifndef ADCBR_CONSTS_VH
`define ADCBR_CONSTS_VH
// Register byte offsets.
`define ADCBR_OFS_CTRL 8'h00
`define ADCBR_OFS_STATUS 8'h04
`define ADCBR_OFS_RESULT 8'h08
`define ADCBR_OFS_START 8'h0c
// Control register fields.
`define ADCBR_CTRL_MODE 1:0
`define ADCBR_CTRL_HWSW 2
`define ADCBR_CTRL_EXTINT 3
`define ADCBR_CTRL_RDC 4
`define ADCBR_CTRL_INV 5
`define ADCBR_CTRL_SPAN 6
`define ADCBR_CTRL_POL 7
`define ADCBR_CTRL_W 8
`define ADCBR_CTRL_RST 8'h04
// Serial mode code and configuration word layout.
`define ADCBR_MODE_SERIAL 2'h3
`define ADCBR_CFG_W 4
`define ADCBR_CFG_POL 3
`define ADCBR_CFG_SPAN 2
`define ADCBR_CFG_RDC 1
`define ADCBR_CFG_EXTINT 0
// Timing: clock rate in MHz and busy times in ns.
`define ADCBR_CLK_MHZ 200
`define ADCBR_T_BUSY_NS 1000
`define ADCBR_T_BUSY_MRC_NS 1500
`define ADCBR_BUSY_CYC ((`ADCBR_T_BUSY_NS * `ADCBR_CLK_MHZ + 999) / 1000)
`define ADCBR_BUSY_MRC_CYC ((`ADCBR_T_BUSY_MRC_NS * `ADCBR_CLK_MHZ + 999) / 1000)
`define ADCBR_CNT_W 12
`define ADCBR_RES_W 18
`endif

// ==== design/adcbr_cfg_shift.v ====
// Serial configuration port receiver and configuration register.
`timescale 1ns/100ps
`include "adcbr_consts.vh"
module adcbr_cfg_shift #(
  parameter CFG_W = `ADCBR_CFG_W
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Port enable and edge invert, with the synchronised serial configuration pins.
  input wire enable,
  input wire sel_n,
  input wire sclk,
  input wire sdin,
  input wire invert,
  // Clear from the falling edge of the conversion reset.
  input wire clear,
  // Latched configuration word.
  output reg [CFG_W-1:0] cfg
);
  reg sclk_d;
  reg sel_n_d;
  reg [CFG_W-1:0] shift;
  wire rise;
  wire fall;
  wire active_edge;

  // Edge detection on the already synchronised serial clock.
  assign rise = sclk & ~sclk_d;
  assign fall = ~sclk & sclk_d;
  assign active_edge = invert ? fall : rise;

  ////////////////////////////////////////////////////////////////////////
  // MSB-first capture
  // Bits enter at the bottom so the first bit ends at the top; the word
  // only takes effect when select returns high, so a partial shift is harmless.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_d <= 1'b0;
      sel_n_d <= 1'b1;
      shift <= {CFG_W{1'b0}};
      cfg <= {CFG_W{1'b0}};
    end
    else
    begin
      sclk_d <= sclk;
      sel_n_d <= sel_n;
      if (clear)
      begin
        shift <= {CFG_W{1'b0}};
        cfg <= {CFG_W{1'b0}};
      end
      else if (enable && !sel_n)
      begin
        if (active_edge)
          shift <= {shift[CFG_W-2:0], sdin};
      end
      else if (enable && sel_n && !sel_n_d)
        cfg <= shift;
    end
  end
endmodule // adcbr_cfg_shift

// ==== design/adcbr_top.v ====
// Converter busy output, shared result/select pin and input range decode.
`timescale 1ns/100ps
`include "adcbr_consts.vh"

module adcbr_top #(
  parameter RES_W = `ADCBR_RES_W,
  parameter BUSY_CYC = `ADCBR_BUSY_CYC,
  parameter BUSY_MRC_CYC = `ADCBR_BUSY_MRC_CYC
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Converter pins from outside.
  input wire cnvst_n,
  input wire conv_reset,
  input wire config_serial_input,
  input wire config_serial_clock,
  // Converter core result, same clock.
  input wire [RES_W-1:0] core_result,
  // Shared pin: result MSB out or configuration select in.
  input wire config_port_select_n,
  output reg parallel_result_msb,
  output wire parallel_result_msb_oe_n,
  // Busy, range and result outputs.
  output reg busy,
  output reg [1:0] range_code,
  output reg [RES_W-1:0] result
);
  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;
  localparam NSYNC = 4;

  reg [`ADCBR_CTRL_W-1:0] ctrl;
  reg [1:0] state;
  reg [`ADCBR_CNT_W-1:0] count;
  reg [NSYNC-1:0] sync1;
  reg [NSYNC-1:0] sync2;
  reg cnvst_d;
  reg reset_d;
  reg addr_wr;
  reg [7:0] addr_q;
  reg sw_start;
  wire [NSYNC-1:0] pins_in;
  wire cnvst_s;
  wire reset_s;
  wire sel_n_s;
  wire sclk_s;
  wire sdin_s;
  wire serial_mode;
  wire sw_config;
  wire start;
  wire reset_fall;
  wire mrc_mode;
  wire eff_pol;
  wire eff_span;
  wire [`ADCBR_CFG_W-1:0] cfg;
  wire [`ADCBR_CNT_W-1:0] busy_len;
  wire addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin from outside the clock domain.
  assign pins_in = {cnvst_n, conv_reset, config_port_select_n, config_serial_clock};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1)
    begin : g_sync
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end
        else
        begin
          sync1[gi] <= pins_in[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate
  assign cnvst_s = sync2[3];
  assign reset_s = sync2[2];
  assign sel_n_s = sync2[1];
  assign sclk_s = sync2[0];

  // Serial data passes through the same two stages as its clock, so both arrive
  // together; the host changes data away from the active edge.
  reg sdin_1;
  reg sdin_2;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sdin_1 <= 1'b0;
      sdin_2 <= 1'b0;
    end
    else
    begin
      sdin_1 <= config_serial_input;
      sdin_2 <= sdin_1;
    end
  end
  assign sdin_s = sdin_2;

  ////////////////////////////////////////////////////////////////////////
  // Mode decode and the serial configuration port.
  assign serial_mode = (ctrl[`ADCBR_CTRL_MODE] == `ADCBR_MODE_SERIAL);
  assign sw_config = serial_mode && !ctrl[`ADCBR_CTRL_HWSW];
  assign reset_fall = reset_d & ~reset_s;

  adcbr_cfg_shift #(
    .CFG_W(`ADCBR_CFG_W)
  ) u_cfg (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(sw_config),
    .sel_n(sel_n_s),
    .sclk(sclk_s),
    .sdin(sdin_s),
    .invert(ctrl[`ADCBR_CTRL_INV]),
    .clear(reset_fall),
    .cfg(cfg)
  );

  assign eff_pol = sw_config ? cfg[`ADCBR_CFG_POL] : ctrl[`ADCBR_CTRL_POL];
  assign eff_span = sw_config ? cfg[`ADCBR_CFG_SPAN] : ctrl[`ADCBR_CTRL_SPAN];
  assign mrc_mode = serial_mode &&
    !(sw_config ? cfg[`ADCBR_CFG_EXTINT] : ctrl[`ADCBR_CTRL_EXTINT]) &&
    !(sw_config ? cfg[`ADCBR_CFG_RDC] : ctrl[`ADCBR_CTRL_RDC]);
  assign busy_len = mrc_mode ? BUSY_MRC_CYC[`ADCBR_CNT_W-1:0] : BUSY_CYC[`ADCBR_CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // shared pin direction
  // The pin is an input only in serial mode, so the host may drive it then.
  assign parallel_result_msb_oe_n = serial_mode;

  // Registered outputs: range code and result MSB on the shared pin.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      range_code <= 2'h0;
      parallel_result_msb <= 1'b0;
    end
    else
    begin
      range_code <= {eff_pol, eff_span};
      parallel_result_msb <= serial_mode ? 1'b0 : result[RES_W-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: a falling start edge or a software start begins it.
  assign start = (cnvst_d & ~cnvst_s) | sw_start;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      count <= {`ADCBR_CNT_W{1'b0}};
      busy <= 1'b0;
      result <= {RES_W{1'b0}};
      cnvst_d <= 1'b0;
      reset_d <= 1'b0;
    end
    else
    begin
      cnvst_d <= cnvst_s;
      reset_d <= reset_s;
      if (reset_s)
      begin
        state <= ST_IDLE;
        busy <= 1'b0;
        count <= {`ADCBR_CNT_W{1'b0}};
      end
      else
      begin
        if (reset_fall)
          result <= {RES_W{1'b0}};
        case (state)
          ST_IDLE:
          begin
            if (start)
            begin
              state <= ST_CONV;
              busy <= 1'b1;
              count <= busy_len - `ADCBR_CNT_W'h1;
            end
          end
          ST_CONV:
          begin
            // latch then drop busy
            // Busy falls in the same edge as the result lands, so a host
            // using that fall as data ready sees the new word.
            if (count == {`ADCBR_CNT_W{1'b0}})
            begin
              state <= ST_IDLE;
              busy <= 1'b0;
              result <= core_result;
            end
            else
              count <= count - `ADCBR_CNT_W'h1;
          end
          default:
          begin
            state <= ST_IDLE;
            busy <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: no wait states, always OKAY; reads are registered in
  // the address phase so hrdata comes from flip-flops.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_wr <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h00000000;
      ctrl <= `ADCBR_CTRL_RST;
      sw_start <= 1'b0;
    end
    else
    begin
      sw_start <= 1'b0;
      addr_wr <= addr_ok && hwrite;
      if (addr_ok)
        addr_q <= haddr;
      if (addr_ok && !hwrite)
      begin
        case (haddr)
          `ADCBR_OFS_CTRL: hrdata <= {24'h000000, ctrl};
          `ADCBR_OFS_STATUS: hrdata <= {23'h000000, cfg, serial_mode, range_code, mrc_mode, busy};
          `ADCBR_OFS_RESULT: hrdata <= {14'h0000, result};
          default: hrdata <= 32'h00000000;
        endcase
      end
      // Writes land in the data phase; unmapped writes are ignored.
      if (addr_wr)
      begin
        if (addr_q == `ADCBR_OFS_CTRL)
          ctrl <= hwdata[`ADCBR_CTRL_W-1:0];
        else if (addr_q == `ADCBR_OFS_START)
          sw_start <= hwdata[0];
      end
    end
  end
endmodule // adcbr_top

// ==== tb/adcbr_top_props.sv ====
// Port checks for the busy, shared pin and range block.
`timescale 1ns/100ps
module adcbr_top_props #(
  parameter RES_W = 18,
  parameter BUSY_CYC = 4,
  parameter BUSY_MRC_CYC = 6
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Bus and pins.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire conv_reset,
  input wire [RES_W-1:0] core_result,
  // Outputs.
  input wire parallel_result_msb,
  input wire parallel_result_msb_oe_n,
  input wire busy,
  input wire [1:0] range_code,
  input wire [RES_W-1:0] result
);
  reg wr_ctrl, oe_exp;
  reg [1:0] rng_exp;
  reg [15:0] bcnt;
  // Control writes are caught in their data phase; the count gives busy length.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ctrl <= 1'b0;
      oe_exp <= 1'b0;
      rng_exp <= 2'h0;
      bcnt <= 16'h0000;
    end
    else
    begin
      wr_ctrl <= hsel && htrans[1] && hwrite && haddr == 8'h00;
      if (wr_ctrl)
      begin
        oe_exp <= hwdata[1:0] == 2'h3;
        rng_exp <= hwdata[7:6];
      end
      bcnt <= busy ? bcnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || conv_reset);
  property p_oe;
    wr_ctrl |-> ##2 parallel_result_msb_oe_n == oe_exp;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_msb;
    !parallel_result_msb_oe_n && $stable(result) |-> parallel_result_msb == result[RES_W-1];
  endproperty
  a_msb: assert property (p_msb) else $error("msb wrong");
  property p_rise;
    $rose(busy) |-> busy [*4];
  endproperty
  a_rise: assert property (p_rise) else $error("busy short");
  property p_len;
    $fell(busy) |-> bcnt == BUSY_CYC || bcnt == BUSY_MRC_CYC;
  endproperty
  a_len: assert property (p_len) else $error("busy length");
  property p_res;
    $fell(busy) |-> result == $past(core_result);
  endproperty
  a_res: assert property (p_res) else $error("result wrong");
  property p_abort;
    disable iff (!hresetn) conv_reset [*4] |-> !busy;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_clr;
    disable iff (!hresetn) $fell(conv_reset) |-> ##[3:6] result == 0;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_rng;
    wr_ctrl && hwdata[2] |-> ##2 range_code == rng_exp;
  endproperty
  a_rng: assert property (p_rng) else $error("range wrong");
endmodule // adcbr_top_props
bind adcbr_top adcbr_top_props #(.RES_W(RES_W), .BUSY_CYC(BUSY_CYC), .BUSY_MRC_CYC(BUSY_MRC_CYC)) i_props (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .conv_reset, .core_result,
  .parallel_result_msb, .parallel_result_msb_oe_n, .busy, .range_code, .result);

// ==== tb/adcbr_host_model.sv ====
// Host model driving conversion start and serial configuration pins.
`timescale 1ns/100ps
module adcbr_host_model (
  // Clock.
  input wire hclk,
  // Pins toward the converter.
  output reg cnvst_n,
  output reg sel_n,
  output reg sclk,
  output reg sdin
);
  integer i;
  // Idle levels.
  initial
  begin
    cnvst_n = 1'b1;
    sel_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // Start pulse held long enough for the pin synchroniser.
  task start;
  begin
    cnvst_n <= 1'b0;
    repeat (3) @(posedge hclk);
    cnvst_n <= 1'b1;
  end
  endtask
  task send_cfg(input [3:0] w, input inv);
  begin
    sclk <= inv;
    @(posedge hclk);
    sel_n <= 1'b0;
    for (i = 3; i >= 0; i = i - 1)
    begin
      sdin <= w[i];
      repeat (4) @(posedge hclk);
      sclk <= ~inv;
      repeat (4) @(posedge hclk);
      sclk <= inv;
    end
    repeat (4) @(posedge hclk);
    sel_n <= 1'b1;
    sdin <= ~w[0];
  end
  endtask
endmodule // adcbr_host_model

// ==== tb/adcbr_top_bench.sv ====
// Self-checking bench for the busy, shared pin and range block.
`timescale 1ns/100ps
module adcbr_top_bench;
  reg hclk, hresetn, hsel, hwrite, conv_reset, rd_dp;
  reg [7:0] haddr;
  reg [1:0] htrans;
  reg [31:0] hwdata, v, rq[$], cq[$];
  reg [17:0] core_result;
  reg [3:0] w;
  wire hreadyout, hresp, cnvst_n, sel_n, sclk, sdin, msb, oe_n, busy;
  wire [31:0] hrdata;
  wire [1:0] range_code;
  wire [17:0] result;
  integer err_total, checks_done, seed, bc, k;
  // The shared pin carries the block's bit when enabled, else the host select.
  wire pin = oe_n ? sel_n : msb;
  adcbr_top #(.BUSY_CYC(4), .BUSY_MRC_CYC(6)) i_adcbr_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cnvst_n(cnvst_n), .conv_reset(conv_reset), .config_serial_input(sdin),
    .config_serial_clock(sclk), .core_result(core_result), .config_port_select_n(pin),
    .parallel_result_msb(msb), .parallel_result_msb_oe_n(oe_n), .busy(busy),
    .range_code(range_code), .result(result));
  adcbr_host_model i_adcbr_host_model (.hclk(hclk), .cnvst_n(cnvst_n), .sel_n(sel_n), .sclk(sclk), .sdin(sdin));
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // One single transfer; waits on the ready of each phase.
  task ahb(input wr, input [7:0] a, input [31:0] d);
  begin
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
  end
  endtask
  task rd(input [7:0] a, input [31:0] e);
  begin
    rq.push_back(e);
    ahb(1'b0, a, 32'h0);
  end
  endtask
  // Conversion with a fresh random core value; src 0 uses the pin.
  task conv(input src, input [7:0] len);
  begin
    v = $random(seed);
    core_result <= v[17:0];
    cq.push_back({len, 6'h00, v[17:0]});
    if (src)
      ahb(1'b1, 8'h0c, 32'h1);
    else
      i_adcbr_host_model.start;
    for (k = 0; k < 40 && cq.size() != 0; k = k + 1) @(posedge hclk);
    // A conversion that never ends leaves its note behind; count it as a miss.
    if (cq.size() != 0)
      chk(32'h0, cq.pop_front());
  end
  endtask
  task finish_test;
  begin
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  // Monitor: read data and finished conversions against the oldest notes.
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout)
    begin
      chk(hrdata, rq.pop_front());
      chk({31'h0, hresp}, 32'h0);
    end
    if (busy)
      bc = bc + 1;
    else if (bc != 0)
    begin
      if (!conv_reset)
        chk({bc[7:0], 6'h00, result}, cq.pop_front());
      bc = 0;
    end
    if (hreadyout)
      rd_dp <= hsel && htrans[1] && !hwrite;
  end
  initial
  begin
    #100000;
    err_total = err_total + 1;
    finish_test;
  end
  initial
  begin
    {err_total, checks_done, bc, rd_dp, hwrite, htrans, haddr, hwdata, core_result} = 0;
    {hresetn, conv_reset} = 2'b00;
    hsel = 1'b1;
    seed = 32'hdb5ad213;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(8'h00, 32'h04);
    rd(8'h10, 32'h0);
    chk(oe_n, 1'b0);
    // Modes 2 and 1 alternate so both nonzero parallel mode codes drive the pin.
    for (w = 0; w < 4; w = w + 1)
    begin
      ahb(1'b1, 8'h00, {24'h0, w[1:0], 4'h1, ~w[0], w[0]});
      repeat (2) @(posedge hclk);
      chk(range_code, w[1:0]);
      chk(oe_n, 1'b0);
    end
    conv(1'b0, 8'd4);
    repeat (2) @(posedge hclk);
    chk(msb, v[17]);
    conv(1'b1, 8'd4);
    rd(8'h08, {14'h0, v[17:0]});
    ahb(1'b1, 8'h00, 32'h03);
    w = {v[3:2], 2'b01};
    i_adcbr_host_model.send_cfg(w, 1'b0);
    repeat (6) @(posedge hclk);
    chk(range_code, w[3:2]);
    chk(oe_n, 1'b1);
    rd(8'h04, {23'h0, w, 1'b1, w[3:2], 2'b00});
    conv(1'b0, 8'd4);
    ahb(1'b1, 8'h00, 32'h23);
    w = {~w[3:2], 2'b00};
    i_adcbr_host_model.send_cfg(w, 1'b1);
    repeat (6) @(posedge hclk);
    rd(8'h04, {23'h0, w, 1'b1, w[3:2], 2'b10});
    conv(1'b0, 8'd6);
    i_adcbr_host_model.start;
    conv_reset <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(busy, 1'b0);
    conv_reset <= 1'b0;
    repeat (6) @(posedge hclk);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h12);
    repeat (4) @(posedge hclk);
    // Every note taken must have been matched by an answer.
    chk(rq.size() + cq.size(), 32'h0);
    finish_test;
  end
endmodule // adcbr_top_bench
